// *** pkg/sdm_pkg.sv ***
package sdm_pkg;
    // symbol geometry
    localparam int SYM_W = 10;
    localparam int MAX_SYMS = 4;
    localparam int WORD_W = SYM_W * MAX_SYMS;
    // width modes for the parallel symbol port
    typedef enum logic [1:0] {
        sdm_w10 = 2'h0,
        sdm_w20 = 2'h1,
        sdm_w40 = 2'h2
    } sdm_width_t;
    // management parameter space
    localparam int PID_W = 4;
    localparam int PVAL_W = 32;
    localparam int NUM_PARAMS = 16;
    localparam logic [PVAL_W-1:0] PARAM_RST = 32'h0000_0000;
    localparam int STATUS_W = 4;
    localparam logic [STATUS_W-1:0] STATUS_RST = 4'h0;
    // tx staging buffer
    localparam int TXF_DEPTH = 8;
    // receive gearbox history: one previous word is kept
    localparam int RX_HIST_W = 2 * WORD_W;

    typedef struct packed {
        logic wr;
        logic [PID_W-1:0] id;
        logic [PVAL_W-1:0] value;
    } sdm_mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic [STATUS_W-1:0] status;
    } sdm_link_note_t;
endpackage : sdm_pkg

// *** src/sdm_fifo.sv ***
`timescale 1ns/100ps
module sdm_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : sdm_fifo

// *** src/sdm_port.sv ***
`timescale 1ns/100ps
// Functional notes
// - tx symbols pass already coded; rx bits pass unaligned, no alignment here.
// - transmit and receive paths are separate and independent.
// - each direction runs at 10, 20 or 40 bits, chosen per direction.
// - 10-bit mode carries exactly one whole symbol per transmit word.
// - 20-bit mode carries two whole symbols per transmit word.
// - 40-bit mode carries four whole symbols per transmit word.
// - 10-bit receive word may split across two symbols; never assumed aligned.
// - 20-bit receive word may hold partial, whole, and partial symbols.
// - 40-bit receive word may hold partial, three whole, partial symbols.
// - write request carries id and value; that parameter takes the value.
// - read request carries id only; response returns that parameter's value.
// - a status notice goes to the user whenever link status changes.
// - first symbol of a word sits lowest and is transmitted first.
module sdm_port
    import sdm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // width selection, sampled only while srst is asserted
    input wire sdm_width_t tx_width,
    input wire sdm_width_t rx_width,
    // symbol source from the encoder
    input wire logic sym_valid,
    output logic sym_ready,
    input wire logic [SYM_W-1:0] sym_data,
    // transmit word toward the serialiser
    output logic [WORD_W-1:0] tx_parallel_symbols,
    output logic tx_word_valid,
    // receive word from the deserialiser
    input wire logic [WORD_W-1:0] rx_parallel_bits,
    input wire logic rx_signal,
    // unaligned receive window for the aligner
    output logic [RX_HIST_W-1:0] rx_window,
    output logic rx_window_valid,
    output logic rx_signal_seen,
    // management requests
    input wire logic mgmt_req_valid,
    output logic mgmt_req_ready,
    input wire sdm_mgmt_req_t mgmt_req,
    output logic rd_resp_valid,
    input wire logic rd_resp_ready,
    output logic [PVAL_W-1:0] rd_resp_value,
    // link status source and notice
    input wire logic [STATUS_W-1:0] link_status,
    output sdm_link_note_t link_note
);
    typedef enum logic [0:0] {
        sdm_idle,
        sdm_resp
    } sdm_mgmt_state_t;

    // symbols per transmit word for a width mode
    function automatic logic [2:0] syms_per_word(input sdm_width_t w);
        unique case (w)
            sdm_w10: syms_per_word = 3'h1;
            sdm_w20: syms_per_word = 3'h2;
            sdm_w40: syms_per_word = 3'h4;
            default: syms_per_word = 3'h1;
        endcase
    endfunction : syms_per_word

    // complete word for the active width; slots above it stay zero so
    // a narrow serialiser never sees stale symbols
    function automatic logic [WORD_W-1:0] tx_word(
        input sdm_width_t w,
        input logic [SYM_W-1:0] last_sym,
        input logic [SYM_W-1:0] s0,
        input logic [SYM_W-1:0] s1,
        input logic [SYM_W-1:0] s2
    );
        tx_word = '0;
        unique case (w)
            sdm_w10: begin
                tx_word[SYM_W-1:0] = last_sym;
            end
            sdm_w20: begin
                tx_word[2*SYM_W-1:0] = {last_sym, s0};
            end
            default: begin
                tx_word = {last_sym, s2, s1, s0};
            end
        endcase
    endfunction : tx_word

    // keep the active width of both words, zero above; the aligner
    // needs the older word to rebuild a symbol cut at the word edge
    function automatic logic [RX_HIST_W-1:0] rx_pair(
        input sdm_width_t w,
        input logic [WORD_W-1:0] newer,
        input logic [WORD_W-1:0] older
    );
        rx_pair = '0;
        unique case (w)
            sdm_w10: begin
                rx_pair[2*SYM_W-1:0] =
                    {newer[SYM_W-1:0], older[SYM_W-1:0]};
            end
            sdm_w20: begin
                rx_pair[4*SYM_W-1:0] =
                    {newer[2*SYM_W-1:0], older[2*SYM_W-1:0]};
            end
            default: begin
                rx_pair = {newer, older};
            end
        endcase
    endfunction : rx_pair

    // widths are taken only in reset so a change cannot split a word
    // across two geometries; a new width needs a fresh reset
    sdm_width_t tx_mode;
    sdm_width_t rx_mode;

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_mode <= tx_width;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_mode <= rx_width;
        end
    end

    // ---------------- transmit path ----------------
    logic [SYM_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [SYM_W-1:0] pack [MAX_SYMS];
    logic [2:0] fill;
    logic [2:0] tx_need;
    logic word_done;

    sdm_fifo #(
        .WIDTH(SYM_W),
        .DEPTH(TXF_DEPTH)
    ) u_txf (
        .mclk(mclk),
        .srst(srst),
        .in_valid(sym_valid),
        .in_ready(sym_ready),
        .in_data(sym_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    assign tx_need = syms_per_word(tx_mode);
    // packing never stalls the fifo, a symbol is popped every cycle one waits; the
    // serialiser takes a word every cycle it is flagged valid
    assign fifo_pop = fifo_valid;
    assign word_done = fifo_pop && (fill + 3'h1 == tx_need);

    // coded symbols are passed untouched, no alignment applied
    always_ff @(posedge mclk) begin
        if (srst) begin
            fill <= '0;
        end else if (fifo_pop) begin
            fill <= word_done ? 3'h0 : fill + 3'h1;
        end
    end

    generate
        for (genvar i = 0; i < MAX_SYMS; i++) begin : g_pack
            always_ff @(posedge mclk) begin
                if (srst) begin
                    pack[i] <= '0;
                end else if (fifo_pop && fill == 3'(i)) begin
                    pack[i] <= fifo_data; // first symbol lands lowest
                end
            end
        end
    endgenerate

    // slots above the active width read zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_parallel_symbols <= '0;
            tx_word_valid <= 1'b0;
        end else begin
            tx_word_valid <= word_done;
            if (word_done) begin
                tx_parallel_symbols <=
                    tx_word(tx_mode, fifo_data, pack[0], pack[1], pack[2]);
            end
        end
    end

    // ---------------- receive path ----------------
    logic [WORD_W-1:0] rx_s1;
    logic [WORD_W-1:0] rx_s2;
    logic [WORD_W-1:0] rx_prev;
    logic sig_sync;

    // receive word enters from the deserialiser domain: two flops
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
            rx_prev <= '0;
        end else begin
            rx_s1 <= rx_parallel_bits;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    sdm_sync u_sig (
        .mclk(mclk),
        .srst(srst),
        .din(rx_signal),
        .dout(sig_sync)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_signal_seen <= 1'b0;
            rx_window_valid <= 1'b0;
        end else begin
            rx_signal_seen <= sig_sync;
            rx_window_valid <= sig_sync;
        end
    end

    // two consecutive words side by side let the aligner find symbols
    // that straddle a word edge; only the active width is kept
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_window <= '0;
        end else begin
            rx_window <= rx_pair(rx_mode, rx_s2, rx_prev);
        end
    end

    // ---------------- management ----------------
    logic [PVAL_W-1:0] params [NUM_PARAMS];
    sdm_mgmt_state_t mstate;
    // ready is a flop, so a read is refused from the cycle after it is
    // taken until its response is accepted
    logic req_take;

    assign req_take = mgmt_req_valid && mgmt_req_ready;

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int k = 0; k < NUM_PARAMS; k++) begin
                params[k] <= PARAM_RST;
            end
        end else if (req_take && mgmt_req.wr) begin
            params[mgmt_req.id] <= mgmt_req.value;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mstate <= sdm_idle;
            mgmt_req_ready <= 1'b0;
            rd_resp_valid <= 1'b0;
            rd_resp_value <= '0;
        end else begin
            unique case (mstate)
                sdm_idle: begin
                    mgmt_req_ready <= 1'b1;
                    if (req_take && !mgmt_req.wr) begin
                        rd_resp_value <= params[mgmt_req.id];
                        rd_resp_valid <= 1'b1;
                        mgmt_req_ready <= 1'b0;
                        mstate <= sdm_resp;
                    end
                end
                sdm_resp: begin
                    if (rd_resp_ready) begin
                        rd_resp_valid <= 1'b0;
                        mgmt_req_ready <= 1'b1;
                        mstate <= sdm_idle;
                    end
                end
            endcase
        end
    end

    // ---------------- link status notice ----------------
    // history resets to the status reset value, so a nonzero status
    // right after reset still gives a notice
    logic [STATUS_W-1:0] st_last;

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_last <= STATUS_RST;
            link_note <= '0;
        end else begin
            st_last <= link_status;
            link_note.valid <= (link_status != st_last);
            link_note.status <= link_status;
        end
    end
endmodule : sdm_port

// *** src/sdm_sync.sv ***
`timescale 1ns/100ps
module sdm_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // level crossing
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : sdm_sync

// *** test/sdm_port_properties.sv ***
`timescale 1ns/100ps
module sdm_chk
    import sdm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // watched ports
    input wire sdm_width_t tx_width,
    input wire sdm_width_t rx_width,
    input wire logic [WORD_W-1:0] tx_parallel_symbols,
    input wire logic tx_word_valid,
    input wire logic rx_signal,
    input wire logic [RX_HIST_W-1:0] rx_window,
    input wire logic rx_window_valid,
    input wire logic rx_signal_seen,
    input wire logic mgmt_req_valid,
    input wire logic mgmt_req_ready,
    input wire sdm_mgmt_req_t mgmt_req,
    input wire logic rd_resp_valid,
    input wire logic rd_resp_ready,
    input wire logic [PVAL_W-1:0] rd_resp_value,
    input wire logic [STATUS_W-1:0] link_status,
    input wire sdm_link_note_t link_note
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_note;
        link_status != $past(link_status) |=>
            link_note.valid && link_note.status == $past(link_status);
    endproperty
    a_note: assert property (p_note)
        else $error("status notice wrong");
    property p_rd_ans;
        mgmt_req_valid && mgmt_req_ready && !mgmt_req.wr |=> rd_resp_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered");
    property p_hold;
        rd_resp_valid && !rd_resp_ready |=>
            rd_resp_valid && $stable(rd_resp_value);
    endproperty
    a_hold: assert property (p_hold)
        else $error("response not held");
    property p_drop;
        rd_resp_valid && rd_resp_ready |=> !rd_resp_valid && mgmt_req_ready;
    endproperty
    a_drop: assert property (p_drop)
        else $error("response repeated");
    property p_refuse;
        rd_resp_valid |-> !mgmt_req_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("request taken while pending");
    property p_tx10;
        tx_word_valid && tx_width == sdm_w10 |->
            tx_parallel_symbols[WORD_W-1:SYM_W] == '0;
    endproperty
    a_tx10: assert property (p_tx10)
        else $error("extra bits in narrow word");
    property p_sig;
        rx_signal [*4] |-> rx_signal_seen && rx_window_valid;
    endproperty
    a_sig: assert property (p_sig)
        else $error("signal detect lost");
    property p_win10;
        rx_width == sdm_w10 |-> rx_window[RX_HIST_W-1:2*SYM_W] == '0;
    endproperty
    a_win10: assert property (p_win10)
        else $error("window above active width");
endmodule : sdm_chk

bind sdm_port sdm_chk u_chk (.*);

// *** test/sdm_serdes_model.sv ***
`timescale 1ns/100ps
module sdm_serdes_model
    import sdm_pkg::*;
(
    // clock
    input wire logic mclk,
    // bench command: far end has signal
    input wire logic sig_on,
    // from the port
    input wire logic [WORD_W-1:0] tx_parallel_symbols,
    input wire logic tx_word_valid,
    // toward the port
    output logic [WORD_W-1:0] rx_parallel_bits,
    output logic rx_signal
);
    logic [WORD_W-1:0] last;
    initial begin
        last = '0;
        rx_parallel_bits = '0;
        rx_signal = 1'b0;
    end
    // loopback skewed 3 bits so symbols never start on a word edge
    always @(posedge mclk) begin
        if (tx_word_valid) begin
            last <= tx_parallel_symbols;
        end
        rx_signal <= sig_on;
        // no signal: noise that changes every cycle
        rx_parallel_bits <= sig_on ? {last[2:0], last[WORD_W-1:3]}
                                   : ~rx_parallel_bits;
    end
endmodule : sdm_serdes_model

// *** test/tb_sdm_port.sv ***
`timescale 1ns/100ps
module tb_sdm_port;
    import sdm_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    sdm_width_t tx_width = sdm_w10;
    sdm_width_t rx_width = sdm_w10;
    logic sym_valid = 1'b0;
    logic [SYM_W-1:0] sym_data = '0;
    logic mgmt_req_valid = 1'b0;
    logic rd_resp_ready = 1'b0;
    sdm_mgmt_req_t mgmt_req = '0;
    logic [STATUS_W-1:0] link_status = '0;
    logic sig_on = 1'b0;
    logic sym_ready, tx_word_valid, rx_signal, rx_window_valid;
    logic rx_signal_seen, mgmt_req_ready, rd_resp_valid;
    logic [WORD_W-1:0] tx_parallel_symbols, rx_parallel_bits;
    logic [RX_HIST_W-1:0] rx_window;
    logic [PVAL_W-1:0] rd_resp_value;
    sdm_link_note_t link_note;
    int fail_count = 0;
    int samples_checked = 0;
    logic [WORD_W-1:0] words[$];
    logic [STATUS_W-1:0] notes[$];

    always #4 mclk = ~mclk;
    sdm_port DUT (.*);
    sdm_serdes_model u_far (.*);

    always @(posedge mclk) begin
        if (tx_word_valid === 1'b1) words.push_back(tx_parallel_symbols);
        if (link_note.valid === 1'b1) notes.push_back(link_note.status);
    end

    task automatic chk(string n, logic [RX_HIST_W-1:0] e,
                       logic [RX_HIST_W-1:0] g);
        samples_checked++;
        if (e !== g) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic wt(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (s !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask : wt

    task automatic rst(sdm_width_t w);
        srst = 1'b1;
        tx_width = w;
        rx_width = w;
        link_status = '0;
        repeat (10) @(posedge mclk);
        #1 srst = 1'b0;
        words.delete();
        notes.delete();
        @(posedge mclk);
        #1;
    endtask : rst

    function automatic logic [WORD_W-1:0] word(int k, int j);
        logic [WORD_W-1:0] e = '0;
        for (int s = 0; s < k; s++) e[s*SYM_W +: SYM_W] = 10'h3c0 + 10'(j*k+s);
        return e;
    endfunction : word

    task automatic t_tx(sdm_width_t w, int k);
        rst(w);
        for (int i = 0; i < 4; i++) begin
            sym_data = 10'h3c0 + 10'(i);
            sym_valid = 1'b1;
            wt(sym_ready);
            @(posedge mclk);
            #1;
        end
        sym_valid = 1'b0;
        repeat (6) @(posedge mclk);
        chk("word count", 4 / k, words.size());
        for (int j = 0; j < 4 / k; j++) chk("tx word", word(k, j), words[j]);
    endtask : t_tx

    task automatic t_rx(int k);
        logic [WORD_W-1:0] e, r;
        logic [RX_HIST_W-1:0] x = '0;
        e = word(k, 4 / k - 1);
        r = {e[2:0], e[WORD_W-1:3]};
        for (int b = 0; b < SYM_W * k; b++) {x[b], x[b+SYM_W*k]} = {2{r[b]}};
        sig_on = 1'b1;
        wt(rx_signal_seen);
        repeat (4) @(posedge mclk);
        #1;
        chk("rx window", x, rx_window);
        chk("window valid", 1'b1, rx_window_valid);
        #1 sig_on = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk("signal seen", 1'b0, rx_signal_seen);
    endtask : t_rx

    task automatic t_stat();
        link_status = 4'h5;
        @(posedge mclk);
        #1 link_status = 4'h9;
        repeat (6) @(posedge mclk);
        chk("notices", 2, notes.size());
        chk("notice a", 4'h5, notes[0]);
        chk("notice b", 4'h9, notes[1]);
    endtask : t_stat

    task automatic req(logic wr, logic [PID_W-1:0] id, logic [PVAL_W-1:0] v);
        mgmt_req = '{wr, id, v};
        mgmt_req_valid = 1'b1;
        wt(mgmt_req_ready);
        @(posedge mclk);
        #1;
    endtask : req

    task automatic rd(logic [PID_W-1:0] id, logic [PVAL_W-1:0] e);
        req(1'b0, id, '0);
        mgmt_req_valid = 1'b0;
        wt(rd_resp_valid);
        // stall so the response must stand
        repeat (2) @(posedge mclk);
        #1 rd_resp_ready = 1'b1;
        chk("read value", e, rd_resp_value);
        @(posedge mclk);
        #1 rd_resp_ready = 1'b0;
    endtask : rd

    task automatic t_mgmt();
        req(1'b1, 4'h3, 32'h1234_abcd);
        req(1'b1, 4'hf, 32'hffff_0001);
        rd(4'h3, 32'h1234_abcd);
        rd(4'hf, 32'hffff_0001);
        rd(4'h0, PARAM_RST);
    endtask : t_mgmt

    initial begin
        t_tx(sdm_w10, 1);
        t_rx(1);
        t_stat();
        t_mgmt();
        t_tx(sdm_w20, 2);
        t_rx(2);
        t_tx(sdm_w40, 4);
        t_rx(4);
        test_done();
    end
endmodule : tb_sdm_port
